// >>> pkg/fse_pkg.sv
// constants, types and helpers shared by the fifo status block
// What this block does
// - live flag bit 0 reads one while the fifo holds all entries
// - live flag bit 1 reads one while the fifo holds nothing
// - live flag bit 2 reads one while level reaches the upper threshold
// - live flag bit 3 reads one while level is at most the lower threshold
// - live flag bit 4 pulses one cycle per write into a full fifo
// - live flag bit 5 pulses one cycle per read from an empty fifo
// - overflow flags a write offered against a low in_ready, underflow a read offered against a low out_valid, as stalling is always on
// - sticky events share live flag positions and set in the same cycle
// - an event bit holds until software writes one to it
// - sticky bit 2 records the level reached the upper threshold
// - sticky bit 3 records the level fell to the lower threshold
// - a newly set event bit with its enable set interrupts the host
// - mask bits 0 to 5 gate the six events, bit 6 enables all
// - registers at word offsets 0 to 5 in the fixed order
// - upper threshold resets to depth minus one, writes clamp to 1..default
// - lower threshold resets to one, writes clamp to 1..upper maximum
// - level register is read-only and shows current occupancy in words
package fse_pkg;

	localparam int DATA_W = 32;
	localparam int DEPTH  = 16;
	localparam int PTR_W  = 4;
	localparam int CNT_W  = 5;
	localparam int AW     = 3;
	localparam int FLAG_W = 6;
	localparam int MASK_W = 7;

	localparam logic [AW-1:0] OFS_LEVEL = 3'h0;
	localparam logic [AW-1:0] OFS_FLAGS = 3'h1;
	localparam logic [AW-1:0] OFS_EVENT = 3'h2;
	localparam logic [AW-1:0] OFS_MASK  = 3'h3;
	localparam logic [AW-1:0] OFS_UPPER = 3'h4;
	localparam logic [AW-1:0] OFS_LOWER = 3'h5;

	localparam int BIT_TOP    = 0;
	localparam int BIT_DRAIN  = 1;
	localparam int BIT_NTOP   = 2;
	localparam int BIT_NBOT   = 3;
	localparam int BIT_WLOSS  = 4;
	localparam int BIT_RLOSS  = 5;
	localparam int BIT_ALL    = 6;

	localparam logic [CNT_W-1:0]  FULL_CNT  = 5'h10;
	localparam logic [CNT_W-1:0]  ZERO_CNT  = 5'h00;
	localparam logic [CNT_W-1:0]  UPPER_RST = 5'h0f;
	localparam logic [CNT_W-1:0]  LOWER_RST = 5'h01;
	localparam logic [CNT_W-1:0]  THR_MIN   = 5'h01;
	localparam logic [FLAG_W-1:0] EVENT_RST = 6'h00;
	localparam logic [FLAG_W-1:0] ALL_EVENT = 6'h3f;
	localparam logic [MASK_W-1:0] MASK_RST  = 7'h00;

	typedef struct packed {
		logic [AW-1:0]     addr;
		logic              read;
		logic              write;
		logic [DATA_W-1:0] wdata;
	} fse_csr_req_t;

	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
		logic             in_ready;
		logic             out_valid;
	} fse_fifo_st_t;

	typedef struct packed {
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] events;
		logic [MASK_W-1:0] mask;
		logic [CNT_W-1:0]  upper;
		logic [CNT_W-1:0]  lower;
		logic [DATA_W-1:0] rdata;
		logic              irq;
	} fse_top_st_t;

	// both thresholds share the same legal range
	function automatic logic [CNT_W-1:0] fse_clamp(
		input logic [DATA_W-1:0] v
	);
		if (v < {27'h0, THR_MIN}) begin
			return THR_MIN;
		end else if (v > {27'h0, UPPER_RST}) begin
			return UPPER_RST;
		end
		return v[CNT_W-1:0];
	endfunction

	function automatic logic [FLAG_W-1:0] fse_eff_mask(
		input logic [MASK_W-1:0] m
	);
		return m[BIT_ALL] ? ALL_EVENT : m[FLAG_W-1:0];
	endfunction

endpackage

// >>> rtl/fse_fifo.sv
// show-ahead fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fse_fifo
	import fse_pkg::*;
#(
	parameter int W = 32,
	parameter int N = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [W-1:0]     in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output var  logic [W-1:0]     out_data,
	input  wire logic             out_ready,
	output var  logic [CNT_W-1:0] level,
	output var  logic [CNT_W-1:0] nxt_level
);

	fse_fifo_st_t st_ff;
	fse_fifo_st_t nxt_st;
	logic         push;
	logic         pop;

	always_comb begin
		push   = in_valid & st_ff.in_ready;
		pop    = out_ready & st_ff.out_valid;
		nxt_st = st_ff;
		nxt_st.wr_ptr = st_ff.wr_ptr + PTR_W'(push);
		nxt_st.rd_ptr = st_ff.rd_ptr + PTR_W'(pop);
		nxt_st.count  = st_ff.count + CNT_W'(push) - CNT_W'(pop);
		nxt_st.in_ready  = nxt_st.count != FULL_CNT;
		nxt_st.out_valid = nxt_st.count != ZERO_CNT;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	fse_mem #(.W(W), .N(N), .A(PTR_W)) u_mem (
		.clk   (clk),
		.we    (push),
		.wa    (st_ff.wr_ptr),
		.wd    (in_data),
		.ra    (nxt_st.rd_ptr),
		.rd_ff (out_data)
	);

	assign in_ready  = st_ff.in_ready;
	assign out_valid = st_ff.out_valid;
	assign level     = st_ff.count;
	assign nxt_level = nxt_st.count;

endmodule
`default_nettype wire

// >>> rtl/fse_mem.sv
// storage array with registered read data and write-through bypass
`timescale 1ns/100ps
`default_nettype none
module fse_mem
	import fse_pkg::*;
#(
	parameter int W = 32,
	parameter int N = 16,
	parameter int A = 4
) (
	input  wire logic         clk,
	input  wire logic         we,
	input  wire logic [A-1:0] wa,
	input  wire logic [W-1:0] wd,
	input  wire logic [A-1:0] ra,
	output var  logic [W-1:0] rd_ff
);

	logic [W-1:0] mem [N];
	logic [W-1:0] nxt_rd;

	// bypass lets a word written into an empty fifo appear at once
	always_comb begin
		nxt_rd = (we && wa == ra) ? wd : mem[ra];
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
		rd_ff <= nxt_rd;
	end

endmodule
`default_nettype wire

// >>> rtl/fse_top.sv
// fifo with live flags, sticky events, interrupt and control registers
`timescale 1ns/100ps
`default_nettype none
module fse_top
	import fse_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              in_valid,
	input  wire logic [DATA_W-1:0] in_data,
	output var  logic              in_ready,
	output var  logic              out_valid,
	output var  logic [DATA_W-1:0] out_data,
	input  wire logic              out_ready,
	input  wire fse_csr_req_t      csr_req,
	output var  logic [DATA_W-1:0] csr_readdata,
	output var  logic              irq
);

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic [1:0] rst_sync_ff;
	logic       rst_sync_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// data path

	logic [CNT_W-1:0] level;
	logic [CNT_W-1:0] nxt_level;

	fse_fifo #(.W(DATA_W), .N(DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_sync_n),
		.in_valid  (in_valid),
		.in_data   (in_data),
		.in_ready  (in_ready),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_ready (out_ready),
		.level     (level),
		.nxt_level (nxt_level)
	);

	////////////////////////////////////////////////////////////////////////
	// flags, events, registers

	fse_top_st_t       st_ff;
	fse_top_st_t       nxt_st;
	logic              wr_loss;
	logic              rd_loss;
	logic [FLAG_W-1:0] clr_bits;
	logic [FLAG_W-1:0] live;
	logic              wr_hit;

	always_comb begin
		nxt_st = st_ff;
		wr_hit = csr_req.write;
		// stalling is always on for the ready ports, so a loss is a write
		// offered against a low in_ready or a read against a low out_valid
		wr_loss = in_valid & ~in_ready;
		rd_loss = out_ready & ~out_valid;
		live = '0;
		live[BIT_TOP]   = nxt_level == FULL_CNT;
		live[BIT_DRAIN] = nxt_level == ZERO_CNT;
		live[BIT_NTOP]  = nxt_level >= st_ff.upper;
		live[BIT_NBOT]  = nxt_level <= st_ff.lower;
		live[BIT_WLOSS] = wr_loss;
		live[BIT_RLOSS] = rd_loss;
		nxt_st.flags = live;
		clr_bits = '0;
		if (wr_hit && csr_req.addr == OFS_EVENT) begin
			clr_bits = csr_req.wdata[FLAG_W-1:0];
		end
		// set beats clear so an event in the clearing cycle survives
		nxt_st.events = (st_ff.events & ~clr_bits) | live;
		// near bits latch whenever the live comparison holds
		if (wr_hit) begin
			case (csr_req.addr)
				OFS_MASK: begin
					nxt_st.mask = csr_req.wdata[MASK_W-1:0];
				end
				OFS_UPPER: begin
					nxt_st.upper = fse_clamp(csr_req.wdata);
				end
				OFS_LOWER: begin
					nxt_st.lower = fse_clamp(csr_req.wdata);
				end
				default: begin
				end
			endcase
		end
		if (csr_req.read) begin
			case (csr_req.addr)
				OFS_LEVEL: begin
					nxt_st.rdata = {27'h0, level};
				end
				OFS_FLAGS: begin
					nxt_st.rdata = {26'h0, st_ff.flags};
				end
				OFS_EVENT: begin
					nxt_st.rdata = {26'h0, st_ff.events};
				end
				OFS_MASK: begin
					nxt_st.rdata = {25'h0, st_ff.mask};
				end
				OFS_UPPER: begin
					nxt_st.rdata = {27'h0, st_ff.upper};
				end
				OFS_LOWER: begin
					nxt_st.rdata = {27'h0, st_ff.lower};
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
		end
		// level output: a fresh set raises it, it holds while set
		nxt_st.irq = |(nxt_st.events & fse_eff_mask(nxt_st.mask));
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_ff.flags  <= EVENT_RST;
			st_ff.events <= EVENT_RST;
			st_ff.mask   <= MASK_RST;
			st_ff.upper  <= UPPER_RST;
			st_ff.lower  <= LOWER_RST;
			st_ff.rdata  <= '0;
			st_ff.irq    <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign csr_readdata = st_ff.rdata;
	assign irq          = st_ff.irq;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	logic [FLAG_W-1:0] past_clr;
	logic              past_wr_loss;
	logic              past_rd_loss;
	logic [CNT_W-1:0]  past_upper;
	logic [CNT_W-1:0]  past_lower;
	logic              seen_ff;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			past_clr     <= '0;
			past_wr_loss <= 1'b0;
			past_rd_loss <= 1'b0;
			past_upper   <= UPPER_RST;
			past_lower   <= LOWER_RST;
			seen_ff      <= 1'b0;
		end else begin
			past_clr     <= clr_bits;
			past_wr_loss <= wr_loss;
			past_rd_loss <= rd_loss;
			past_upper   <= st_ff.upper;
			past_lower   <= st_ff.lower;
			seen_ff      <= 1'b1;
		end
	end

	sequence upper_wr_s;
		csr_req.write && csr_req.addr == OFS_UPPER;
	endsequence

	sequence lower_wr_s;
		csr_req.write && csr_req.addr == OFS_LOWER;
	endsequence

	sequence level_rd_s;
		csr_req.read && csr_req.addr == OFS_LEVEL;
	endsequence

	sequence event_clr_s;
		csr_req.write && csr_req.addr == OFS_EVENT;
	endsequence

	sequence flags_rd_s;
		csr_req.read && csr_req.addr == OFS_FLAGS;
	endsequence

	sequence event_rd_s;
		csr_req.read && csr_req.addr == OFS_EVENT;
	endsequence

	sequence unmapped_rd_s;
		csr_req.read && csr_req.addr > OFS_LOWER;
	endsequence

	// flags keep their reset zero until one edge after release
	top_flag_a: assert property (
		seen_ff |-> st_ff.flags[BIT_TOP] == (level == FULL_CNT))
		else $error("full flag disagrees with level");

	drain_flag_a: assert property (
		seen_ff |-> st_ff.flags[BIT_DRAIN] == (level == ZERO_CNT))
		else $error("empty flag disagrees with level");

	near_top_a: assert property (
		seen_ff |-> st_ff.flags[BIT_NTOP] == (level >= past_upper))
		else $error("near full flag wrong");

	near_bot_a: assert property (
		seen_ff |-> st_ff.flags[BIT_NBOT] == (level <= past_lower))
		else $error("near empty flag wrong");

	write_loss_a: assert property (
		seen_ff |-> st_ff.flags[BIT_WLOSS] == past_wr_loss)
		else $error("overflow pulse wrong");

	read_loss_a: assert property (
		(out_ready && !out_valid) |=> st_ff.flags[BIT_RLOSS])
		else $error("underflow pulse missing");

	sticky_set_a: assert property (
		(st_ff.flags & ~st_ff.events) == '0)
		else $error("live flag without event bit");

	sticky_hold_a: assert property (
		seen_ff |-> ($past(st_ff.events) & ~past_clr & ~st_ff.events) == '0)
		else $error("event bit dropped without clear");

	irq_level_a: assert property (
		seen_ff |-> irq == |($past(nxt_st.events) & fse_eff_mask(st_ff.mask)))
		else $error("interrupt not tied to enabled events");

	upper_clamp_a: assert property (
		upper_wr_s |=> st_ff.upper == fse_clamp($past(csr_req.wdata)))
		else $error("upper threshold not clamped");

	lower_clamp_a: assert property (
		lower_wr_s |=> st_ff.lower == fse_clamp($past(csr_req.wdata)))
		else $error("lower threshold not clamped");

	level_read_a: assert property (
		level_rd_s |=> csr_readdata == {27'h0, $past(level)})
		else $error("level readback wrong");

	event_clear_a: assert property (
		event_clr_s |=> (st_ff.events & past_clr & ~st_ff.flags) == '0)
		else $error("written one left an idle event bit set");

	near_top_hold_a: assert property (
		st_ff.events[BIT_NTOP] && !clr_bits[BIT_NTOP]
			|=> st_ff.events[BIT_NTOP])
		else $error("near full event lost without clear");

	near_bot_hold_a: assert property (
		st_ff.events[BIT_NBOT] && !clr_bits[BIT_NBOT]
			|=> st_ff.events[BIT_NBOT])
		else $error("near empty event lost without clear");

	irq_rise_a: assert property (
		seen_ff && |(st_ff.events & ~$past(st_ff.events)
			& fse_eff_mask(st_ff.mask)) |-> irq)
		else $error("new enabled event raised no interrupt");

	irq_all_a: assert property (
		st_ff.mask[BIT_ALL] && st_ff.events != '0 |-> irq)
		else $error("enable all bit did not pass an event");

	irq_match_a: assert property (
		irq == |(st_ff.events & fse_eff_mask(st_ff.mask)))
		else $error("interrupt outlived its enabled events");

	reset_state_a: assert property (
		$rose(rst_sync_n) |-> st_ff.events == EVENT_RST
			&& st_ff.mask == MASK_RST && !irq)
		else $error("event or enable bits not clear after reset");

	flags_read_a: assert property (
		flags_rd_s |=> csr_readdata == {26'h0, $past(st_ff.flags)})
		else $error("live flags readback wrong");

	event_read_a: assert property (
		event_rd_s |=> csr_readdata == {26'h0, $past(st_ff.events)})
		else $error("sticky events readback wrong");

	unmapped_read_a: assert property (
		unmapped_rd_s |=> csr_readdata == '0)
		else $error("unmapped offset read not zero");

	write_loss_full_a: assert property (
		seen_ff && st_ff.flags[BIT_WLOSS] |-> $past(level) == FULL_CNT)
		else $error("overflow flagged below full");

	read_loss_empty_a: assert property (
		seen_ff && st_ff.flags[BIT_RLOSS] |-> $past(level) == ZERO_CNT)
		else $error("underflow flagged above empty");

endmodule
`default_nettype wire

// >>> test/fifo_status_event_irq_test.sv
// self-checking bench for the fifo status block
`timescale 1ns/100ps
`default_nettype none
module fifo_status_event_irq_test
	import fse_pkg::*;
;
	logic              clk;
	logic              reset_n;
	logic              in_valid;
	logic [DATA_W-1:0] in_data;
	logic              in_ready;
	logic              out_valid;
	logic [DATA_W-1:0] out_data;
	logic              out_ready;
	fse_csr_req_t      csr_req;
	logic [DATA_W-1:0] csr_readdata;
	logic              irq;
	logic [DATA_W-1:0] q;
	logic [DATA_W-1:0] v;
	logic [DATA_W-1:0] model[$];
	int                err_count;
	int                cmp_count;
	int                i;

	fse_top dut (
		.clk(clk), .reset_n(reset_n), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready), .csr_req(csr_req),
		.csr_readdata(csr_readdata), .irq(irq)
	);
	fse_host host (.clk(clk), .csr_req(csr_req), .csr_readdata(csr_readdata));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [DATA_W-1:0] s,
		input logic [DATA_W-1:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [AW-1:0] a, input string n,
		input logic [DATA_W-1:0] e);
		host.acc(a, 1'b0, '0, q);
		chk(n, q, e);
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DATA_W-1:0] d);
		host.acc(a, 1'b1, d, q);
	endtask
	task automatic push(input logic [DATA_W-1:0] d);
		@(negedge clk);
		for (int k = 0; k < 50 && in_ready !== 1'b1; k++) @(negedge clk);
		@(posedge clk);
		in_valid <= 1'b1;
		in_data  <= d;
		@(posedge clk);
		in_valid <= 1'b0;
		in_data  <= ~d;
		model.push_back(d);
	endtask
	task automatic pop();
		@(negedge clk);
		for (int k = 0; k < 50 && out_valid !== 1'b1; k++) @(negedge clk);
		chk("out_data", out_data, model.pop_front());
		@(posedge clk);
		out_ready <= 1'b1;
		@(posedge clk);
		out_ready <= 1'b0;
	endtask
	function automatic logic [DATA_W-1:0] exp_flags(input int l, input int u,
		input int lo);
		exp_flags    = '0;
		exp_flags[0] = (l == DEPTH);
		exp_flags[1] = (l == 0);
		exp_flags[2] = (l >= u);
		exp_flags[3] = (l <= lo);
	endfunction
	function automatic logic [DATA_W-1:0] clampv(input logic [DATA_W-1:0] x);
		clampv = (x < 1) ? 1 : (x > DEPTH - 1) ? DEPTH - 1 : x;
	endfunction
	////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_count++;
		results();
	end
	initial begin
		reset_n   = 1'b0;
		in_valid  = 1'b0;
		in_data   = '0;
		out_ready = 1'b0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(25));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFS_LEVEL, "level", 32'h0);
		rd(OFS_FLAGS, "flags", exp_flags(0, 15, 1));
		rd(OFS_EVENT, "events", 32'h0a);
		rd(OFS_MASK, "mask", 32'h0);
		rd(OFS_UPPER, "upper", 32'hf);
		rd(OFS_LOWER, "lower", 32'h1);
		rd(3'h6, "unmapped", 32'h0);
		wr(OFS_LEVEL, 32'h7);
		rd(OFS_LEVEL, "level ro", 32'h0);
		// clamp corners first, then random values
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff : $urandom_range(20);
			wr(OFS_UPPER, v);
			rd(OFS_UPPER, "upper clamp", clampv(v));
			wr(OFS_LOWER, v);
			rd(OFS_LOWER, "lower clamp", clampv(v));
		end
		wr(OFS_UPPER, 32'hf);
		wr(OFS_LOWER, 32'h1);
		wr(OFS_EVENT, 32'h0);
		rd(OFS_EVENT, "events w0", 32'h0a);
		push($urandom);
		rd(OFS_FLAGS, "flags one", exp_flags(1, 15, 1));
		wr(OFS_EVENT, 32'h3f);
		rd(OFS_EVENT, "events w1c", 32'h08);
		while (model.size() < DEPTH) push($urandom);
		rd(OFS_LEVEL, "level full", DEPTH);
		chk("in_ready full", in_ready, 32'h0);
		// one offer against a full fifo; the word is lost
		@(posedge clk);
		in_valid <= 1'b1;
		@(posedge clk);
		in_valid <= 1'b0;
		rd(OFS_FLAGS, "flags full", exp_flags(DEPTH, 15, 1));
		rd(OFS_EVENT, "events full", 32'h1d);
		while (model.size() > 0) pop();
		rd(OFS_FLAGS, "flags empty", exp_flags(0, 15, 1));
		chk("out_valid empty", out_valid, 32'h0);
		@(posedge clk);
		out_ready <= 1'b1;
		@(posedge clk);
		out_ready <= 1'b0;
		rd(OFS_EVENT, "events empty", 32'h3f);
		chk("irq off", irq, 1'b0);
		wr(OFS_MASK, 32'h10);
		rd(OFS_MASK, "mask", 32'h10);
		chk("irq bit4", irq, 1'b1);
		wr(OFS_EVENT, 32'h10);
		rd(OFS_EVENT, "events cl4", 32'h2f);
		chk("irq cleared", irq, 1'b0);
		wr(OFS_MASK, 32'h40);
		rd(OFS_MASK, "mask all", 32'h40);
		chk("irq all", irq, 1'b1);
		wr(OFS_EVENT, 32'h3f);
		rd(OFS_EVENT, "events live", 32'h0a);
		chk("irq live", irq, 1'b1);
		wr(OFS_MASK, 32'h0);
		rd(OFS_LEVEL, "level", 32'h0);
		chk("irq masked", irq, 1'b0);
		results();
	end
endmodule
`default_nettype wire

// >>> test/fse_host.sv
// processor host model driving the control register port
`timescale 1ns/100ps
`default_nettype none
module fse_host
	import fse_pkg::*;
(
	input  wire logic              clk,
	output var  fse_csr_req_t      csr_req,
	input  wire logic [DATA_W-1:0] csr_readdata
);
	initial begin
		csr_req = '0;
	end
	////////////////////////////////////////////////////////////////////
	// one access per call, dropped at the taking edge
	task automatic acc(input logic [AW-1:0] a, input logic w,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		@(posedge clk);
		csr_req <= '{addr: a, read: !w, write: w, wdata: d};
		@(posedge clk);
		// idle bus shows inverted leftovers so stale values cannot match
		csr_req <= '{addr: ~a, read: 1'b0, write: 1'b0, wdata: ~d};
		// read data holds until the next read, so look a cycle late
		@(posedge clk);
		#1;
		q = csr_readdata;
	endtask
endmodule
`default_nettype wire
